// ==== common/uartrx_pkg.sv ====
// Constants and carrier types for the oversampled serial receiver.
// Assumes one 50 MHz clock and a 16x tick enable supplied from outside.
package uartrx_pkg;
  localparam int unsigned TICKS_PER_BIT  = 16;
  localparam logic [3:0]  TICK_START_A   = 4'h3;
  localparam logic [3:0]  TICK_START_B   = 4'h5;
  localparam logic [3:0]  TICK_START_C   = 4'h7;
  localparam logic [3:0]  TICK_DATA_A    = 4'h8;
  localparam logic [3:0]  TICK_DATA_B    = 4'h9;
  localparam logic [3:0]  TICK_DATA_C    = 4'hA;
  localparam logic [3:0]  TICK_LAST      = 4'hF;
  localparam logic [3:0]  BITS_SHORT     = 4'h8;
  localparam logic [3:0]  BITS_LONG      = 4'h9;
  localparam logic [3:0]  IDLE_SHORT     = 4'hA;
  localparam logic [3:0]  IDLE_LONG      = 4'hB;
  localparam logic [8:0]  DATA_RESET     = 9'h000;

  // Control bits from software
  typedef struct packed {
    logic long_char;          // 9-bit characters
    logic parity_en;
    logic parity_odd;
    logic wake_addr;          // 1 address mark, 0 idle line
    logic idle_count_origin;  // 1 after stop bit, 0 after start bit
    logic rx_full_irq_en;
    logic line_quiet_irq_en;
    logic overrun_irq_en;
    logic noise_irq_en;
    logic framing_irq_en;
    logic parity_irq_en;
  } uartrx_ctrl_t;

  // Status flags shown to software
  typedef struct packed {
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } uartrx_flags_t;
endpackage

// ==== design/uartrx_vote.sv ====
// Three-sample majority voter with disagreement output.
// Assumes samples arrive already synchronised to the clock.
module uartrx_vote
  import uartrx_pkg::*;
(
  input  wire logic [2:0] samples,  // Three samples of one bit
  output logic            level,    // Majority value
  output logic            noisy     // Samples disagree
);
  // Majority and disagreement of three samples
  assign level = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
  assign noisy = (samples != 3'b000) && (samples != 3'b111);
endmodule

// ==== design/uartrx_core.sv ====
// Serial receive path: 16x sampling, start/data/stop recovery, flags, standby.
// Assumes tick_16x is a one-cycle enable at sixteen times the baud rate and
// that software drives the control struct and one-cycle clear pulses.
module uartrx_core
  import uartrx_pkg::*;
(
  input  wire logic          ref_clk,         // 50 MHz clock
  input  wire logic          rst,             // Synchronous reset, active high
  input  wire logic          tick_16x,        // Oversample tick enable
  input  wire logic          rx_pin,          // Receive line, asynchronous
  input  wire uartrx_ctrl_t  ctrl,            // Control bits
  input  wire logic          standby_set,     // Pulse: sets standby request, unless idle-line wake is chosen and the line is already idle
  input  wire logic          data_read,       // Pulse: buffer read, clears full and errors
  input  wire logic          idle_clear,      // Pulse: clears idle flag
  output logic               standby_request, // Receiver in standby
  output uartrx_flags_t      flags,           // Status flags
  output logic [8:0]         rx_data,         // Received data buffer, bit 8 ninth bit
  output logic               rx_irq,          // Receive-full or idle request
  output logic               err_irq          // Error request
);
  typedef enum logic [1:0] {ST_HUNT, ST_START, ST_BITS} uartrx_state_t;

  uartrx_state_t state;
  logic [1:0]    sync;            // Two-stage synchroniser
  logic          rx;
  logic [2:0]    hist;            // Last three tick samples while hunting
  logic [3:0]    tick;            // Position within bit
  logic [3:0]    bit_idx;         // 0 start, then data, then stop
  logic [2:0]    start_smp;
  logic [2:0]    mid_smp;
  logic [9:0]    shifter;
  logic          prev_bit;        // Previous decided bit, for resync
  logic          char_noise;
  logic [3:0]    idle_cnt;
  logic          idle_seen;       // Line idle since last character
  logic          counting_idle;
  logic          vote_lvl;
  logic          vote_noise;
  logic          svote_lvl;
  logic          svote_noise;
  logic [3:0]    last_bit;
  logic [3:0]    idle_need;
  logic          done;
  logic          next_noise;
  logic [8:0]    char_data;
  logic          par_ok;
  logic          wake_mark;
  logic          wake_idle;
  logic          idle_event;
  logic [3:0]    hunt_tick;       // Bit-time count while hunting, for idle

  // Level from pin crosses two flops before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync <= 2'b11;
    end else begin
      sync <= {sync[0], rx_pin};
    end
  end
  assign rx = sync[1];

  uartrx_vote u_start_vote (
    .samples (start_smp),
    .level   (svote_lvl),
    .noisy   (svote_noise)
  );

  uartrx_vote u_mid_vote (
    .samples ({mid_smp[1:0], rx}),
    .level   (vote_lvl),
    .noisy   (vote_noise)
  );

  assign last_bit  = (ctrl.long_char ? BITS_LONG : BITS_SHORT) + 4'h1; // Stop index
  assign idle_need = ctrl.long_char ? IDLE_LONG : IDLE_SHORT;
  assign done      = tick_16x && state == ST_BITS && tick == TICK_DATA_C && bit_idx == last_bit;
  assign next_noise = char_noise | vote_noise;

  // Assemble data; the ninth bit copies bit 7 for short characters
  always_comb begin
    char_data = ctrl.long_char ? shifter[9:1] : {shifter[9], shifter[9:2]};
    if (!ctrl.long_char) begin
      char_data = {shifter[9], shifter[9:2]};
    end
  end
  // Parity bit sits in the top data position, so the whole field is checked
  assign par_ok    = (ctrl.long_char ? ^char_data[8:0] : ^char_data[7:0]) == ctrl.parity_odd;
  // Stop bit is not shifted in yet at done, so the newest data bit is on top
  assign wake_mark = done && standby_request && ctrl.wake_addr && shifter[9];

  // Receive state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state      <= ST_HUNT;
      hist       <= 3'b000;
      tick       <= 4'h0;
      bit_idx    <= 4'h0;
      start_smp  <= 3'b000;
      mid_smp    <= 3'b000;
      shifter    <= 10'h000;
      prev_bit   <= 1'b1;
      char_noise <= 1'b0;
    end else if (tick_16x) begin
      case (state)
        ST_HUNT: begin
          hist <= {hist[1:0], rx};
          if (hist == 3'b111 && !rx) begin
            state      <= ST_START;
            tick       <= 4'h2;
            char_noise <= 1'b0;
            start_smp  <= 3'b000;
          end
        end
        ST_START: begin
          tick <= tick + 4'h1;
          if (tick == TICK_START_A) start_smp[2] <= rx;
          if (tick == TICK_START_B) start_smp[1] <= rx;
          if (tick == TICK_START_C) begin
            if (svote_lvl || {start_smp[2:1], rx} inside {3'b011, 3'b101, 3'b110, 3'b111}) begin
              state <= ST_HUNT;
              tick  <= 4'h0;
              hist  <= 3'b000;
            end else begin
              state      <= ST_BITS;
              bit_idx    <= 4'h0;
              char_noise <= {start_smp[2:1], rx} != 3'b000;
            end
          end
        end
        ST_BITS: begin
          tick <= tick + 4'h1;
          if (tick == TICK_DATA_A) mid_smp[0] <= rx;
          if (tick == TICK_DATA_B) mid_smp <= {mid_smp[0], rx};
          if (tick == TICK_DATA_C) begin
            char_noise <= next_noise;
            if (bit_idx == 4'h0) begin
              prev_bit <= 1'b0;                                  // start kept regardless
            end else begin
              shifter  <= {vote_lvl, shifter[9:1]};
              prev_bit <= vote_lvl;
            end
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == last_bit) begin
              state <= ST_HUNT;
              hist  <= 3'b000;
            end
          end
          // Falling edge after a decided high bit realigns the count
          if (prev_bit && !rx && tick > TICK_DATA_C && bit_idx != last_bit) begin
            tick     <= 4'h2;
            prev_bit <= 1'b0;
          end else if (tick == TICK_LAST) begin
            tick <= 4'h0;
          end
        end
        default: state <= ST_HUNT;
      endcase
    end
  end

  // Idle bit counting; origin chooses start or stop bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idle_cnt      <= 4'h0;
      counting_idle <= 1'b0;
      idle_seen     <= 1'b0;
    end else if (tick_16x) begin
      if (state == ST_BITS && tick == TICK_DATA_C) begin
        if (bit_idx == 4'h0) begin
          counting_idle <= !ctrl.idle_count_origin;
          idle_cnt      <= 4'h0;
          idle_seen     <= 1'b0;
        end else if (bit_idx == last_bit) begin
          counting_idle <= 1'b1;
          if (ctrl.idle_count_origin || !vote_lvl) idle_cnt <= 4'h0;
          else idle_cnt <= idle_cnt + 4'h1;
        end else if (!vote_lvl) begin
          idle_cnt <= 4'h0;
        end else if (counting_idle) begin
          idle_cnt <= idle_cnt + 4'h1;
        end
      end else if (state == ST_HUNT && hunt_tick == TICK_DATA_C && counting_idle) begin
        if (idle_cnt >= idle_need) begin
          idle_seen     <= 1'b1;
          counting_idle <= 1'b0;
        end else begin
          idle_cnt <= idle_cnt + 4'h1;
        end
      end
    end
  end

  // A bit time clock while hunting, used only for idle counting
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hunt_tick <= 4'h0;
    end else if (tick_16x) begin
      hunt_tick <= (state == ST_HUNT) ? hunt_tick + 4'h1 : 4'h0;
    end
  end
  assign idle_event = tick_16x && state == ST_HUNT && hunt_tick == TICK_DATA_C && counting_idle
                      && idle_cnt >= idle_need && rx;

  assign wake_idle = standby_request && !ctrl.wake_addr && idle_event;

  // Standby request bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      standby_request <= 1'b0;
    end else if (standby_set) begin
      standby_request <= !(!ctrl.wake_addr && idle_seen);
    end else if (wake_mark || wake_idle) begin
      standby_request <= 1'b0;
    end
  end

  // Buffer and flags; a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags   <= '0;
      rx_data <= DATA_RESET;
    end else begin
      if (data_read) begin
        flags.rx_full_flag       <= 1'b0;
        flags.overrun_flag       <= 1'b0;
        flags.noise_flag         <= 1'b0;
        flags.framing_error_flag <= 1'b0;
        flags.parity_error_flag  <= 1'b0;
      end
      if (idle_clear) flags.idle_flag <= 1'b0;
      if (idle_event && !wake_idle) flags.idle_flag <= 1'b1;
      if (done && (!standby_request || wake_mark)) begin
        if (flags.rx_full_flag && !data_read) begin
          flags.overrun_flag <= 1'b1;                            // old data kept
        end else begin
          rx_data                  <= char_data;                 // A break already carries zero data
          flags.rx_full_flag       <= 1'b1;
          flags.framing_error_flag <= !vote_lvl;
          flags.noise_flag         <= next_noise;
          flags.parity_error_flag  <= ctrl.parity_en && !par_ok;
        end
      end
    end
  end

  // Interrupt requests, held off entirely during standby
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_irq  <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      rx_irq  <= !standby_request &&
                 ((flags.rx_full_flag && ctrl.rx_full_irq_en) ||
                  (flags.idle_flag && ctrl.line_quiet_irq_en));
      err_irq <= !standby_request &&
                 ((flags.overrun_flag && ctrl.overrun_irq_en) ||
                  (flags.noise_flag && ctrl.noise_irq_en) ||
                  (flags.framing_error_flag && ctrl.framing_irq_en) ||
                  (flags.parity_error_flag && ctrl.parity_irq_en));
    end
  end

  // Checks
  sequence s_char_end;
    done && !standby_request && !flags.rx_full_flag;
  endsequence

  a_full_sets: assert property (@(posedge ref_clk) disable iff (rst)
    s_char_end |=> flags.rx_full_flag) else $error("full flag not set");
  a_frame_with_full: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(flags.framing_error_flag) |-> $rose(flags.rx_full_flag)) else $error("framing apart from full");
  a_frame_low_stop: assert property (@(posedge ref_clk) disable iff (rst)
    s_char_end ##0 !vote_lvl |=> flags.framing_error_flag) else $error("framing missed");
  a_overrun_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    done && flags.rx_full_flag && !data_read && !standby_request |=> flags.overrun_flag && $stable(rx_data))
    else $error("overrun lost old data");
  a_standby_mute: assert property (@(posedge ref_clk) disable iff (rst)
    standby_request |=> !rx_irq && !err_irq) else $error("irq during standby");
  a_err_or: assert property (@(posedge ref_clk) disable iff (rst)
    !standby_request && flags.framing_error_flag && ctrl.framing_irq_en |=> err_irq) else $error("err irq missing");
  a_fail_rehunt: assert property (@(posedge ref_clk) disable iff (rst)
    tick_16x && state == ST_START && tick == TICK_START_C && svote_lvl |=> state == ST_HUNT) else $error("bad start kept");
  a_mark_wakes: assert property (@(posedge ref_clk) disable iff (rst)
    wake_mark |=> !standby_request && flags.rx_full_flag) else $error("address mark no wake");
  a_idle_wake_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    wake_idle && !flags.idle_flag |=> !flags.idle_flag) else $error("waking idle set flag");
endmodule

// ==== verification/uartrx_tx_model.sv ====
// Behavioural remote transmitter that drives the receive line.
// Assumes the bench supplies tick_16x; the line idles high between frames.
module uartrx_tx_model (
  input  wire logic ref_clk,  // Bench clock
  input  wire logic tick_16x, // Oversample tick enable
  output logic      rx_line   // Serial line into the receiver
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle level until the first frame
  initial rx_line = 1'b1;

  // Hold one level for n ticks, changing just after a tick edge
  task automatic hold(input logic lvl, input int n);
    rx_line = lvl;
    repeat (n) @(posedge ref_clk iff tick_16x);
    #1;
  endtask

  // One frame, LSB first; glitch names the data bit that gets a one-tick spike
  task automatic send(input logic [8:0] d, input int nd, input logic stop, input int glitch);
    hold(1'b0, 16);
    for (int i = 0; i < nd; i++) begin
      if (i == glitch) begin
        hold(d[i], 9);
        hold(~d[i], 1); // Narrow spike lands inside the 8..10 vote window
        hold(d[i], 6);
      end else begin
        hold(d[i], 16);
      end
    end
    hold(stop, 16);
    hold(1'b1, 16); // Trailing idle bit so the next start edge is seen
  endtask
endmodule

// ==== verification/uartrx_core_tb_top.sv ====
// Self-checking bench for the serial receive path.
// Assumes a 50 MHz clock and a tick every fourth cycle from this bench.
module uartrx_core_tb_top
  import uartrx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic          ref_clk, rst, tick_16x, rx_pin, standby_set, data_read, idle_clear;
  logic          standby_request, rx_irq, err_irq;
  uartrx_ctrl_t  ctrl;
  uartrx_flags_t flags;
  logic [8:0]    rx_data;
  logic [1:0]    tdiv;
  int            mismatches, num_checks, cycles;

  // Clock and tick divider; the tick keeps a short run yet sixteen per bit
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tdiv <= tdiv + 2'h1;
    tick_16x <= #1 (tdiv == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  uartrx_core i_dut (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .tick_16x        (tick_16x),
    .rx_pin          (rx_pin),
    .ctrl            (ctrl),
    .standby_set     (standby_set),
    .data_read       (data_read),
    .idle_clear      (idle_clear),
    .standby_request (standby_request),
    .flags           (flags),
    .rx_data         (rx_data),
    .rx_irq          (rx_irq),
    .err_irq         (err_irq)
  );

  uartrx_tx_model i_tx (
    .ref_clk  (ref_clk),
    .tick_16x (tick_16x),
    .rx_line  (rx_pin)
  );

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flags without idle, which may rise in quiet gaps
  function automatic logic [15:0] fl();
    return {10'h000, flags & 6'h2F};
  endfunction

  // One-cycle pulses on the software strobes
  task automatic rd();
    @(posedge ref_clk);
    #1 data_read = 1'b1;
    @(posedge ref_clk);
    #1 data_read = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic sby();
    @(posedge ref_clk);
    #1 standby_set = 1'b1;
    @(posedge ref_clk);
    #1 standby_set = 1'b0;
  endtask

  // Check a completed character, then read it out
  task automatic got_char(input logic [8:0] d, input logic [5:0] f);
    chk({7'h00, rx_data}, {7'h00, d});
    chk(fl(), {10'h000, f});
    rd();
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, standby_set, data_read, idle_clear, tdiv, tick_16x} = 7'h40;
    {mismatches, num_checks, cycles} = '0;
    ctrl = '0;
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk({10'h000, flags}, 16'h0000);
    {ctrl.rx_full_irq_en, ctrl.line_quiet_irq_en, ctrl.overrun_irq_en} = 3'h7;
    {ctrl.noise_irq_en, ctrl.parity_irq_en} = 2'h3;
    i_tx.hold(1'b1, 48);
    // Plain character, then the irq request and its clear
    i_tx.send(9'h0A5, 8, 1'b1, -1);
    chk({15'h0000, rx_irq}, 16'h0001);
    got_char(9'h1A5, 6'h20);
    // Short low spike is no start bit
    i_tx.hold(1'b0, 2);
    i_tx.hold(1'b1, 32);
    chk(fl(), 16'h0000);
    // Overrun keeps the first character
    i_tx.send(9'h03C, 8, 1'b1, -1);
    i_tx.send(9'h0C3, 8, 1'b1, -1);
    chk({15'h0000, err_irq}, 16'h0001);
    got_char(9'h03C, 6'h28);
    // Noise spike inside a data bit
    i_tx.send(9'h0A5, 8, 1'b1, 2);
    got_char(9'h1A5, 6'h24);
    // Low stop bit with its enable clear, then a break with it set
    i_tx.send(9'h055, 8, 1'b0, -1);
    chk({15'h0000, err_irq}, 16'h0000);
    got_char(9'h055, 6'h22);
    ctrl.framing_irq_en = 1'b1;
    i_tx.send(9'h000, 8, 1'b0, -1);
    chk({15'h0000, err_irq}, 16'h0001);
    got_char(9'h000, 6'h22);
    // Parity: three ones fails even and passes odd
    ctrl.parity_en = 1'b1;
    i_tx.send(9'h083, 8, 1'b1, -1);
    got_char(9'h183, 6'h21);
    ctrl.parity_odd = 1'b1;
    i_tx.send(9'h083, 8, 1'b1, -1);
    got_char(9'h183, 6'h20);
    // Nine-bit character
    {ctrl.parity_en, ctrl.long_char} = 2'h1;
    i_tx.send(9'h15A, 9, 1'b1, -1);
    got_char(9'h15A, 6'h20);
    ctrl.long_char = 1'b0;
    // Address-mark standby: plain byte dropped, marked byte wakes
    ctrl.wake_addr = 1'b1;
    sby();
    chk({15'h0000, standby_request}, 16'h0001);
    i_tx.send(9'h012, 8, 1'b1, -1);
    chk(fl(), 16'h0000);
    chk({15'h0000, rx_irq}, 16'h0000);
    i_tx.send(9'h092, 8, 1'b1, -1);
    chk({15'h0000, standby_request}, 16'h0000);
    got_char(9'h192, 6'h20);
    // Quiet line raises idle and its request
    i_tx.hold(1'b1, 16 * 12);
    chk({15'h0000, flags.idle_flag}, 16'h0001);
    chk({15'h0000, rx_irq}, 16'h0001);
    @(posedge ref_clk);
    #1 idle_clear = 1'b1;
    @(posedge ref_clk);
    #1 idle_clear = 1'b0;
    // Idle-line standby on an already quiet line is not entered
    ctrl.wake_addr = 1'b0;
    sby();
    for (int i = 0; i < 1000 && standby_request === 1'b1; i++) @(posedge ref_clk);
    #1;
    chk({15'h0000, standby_request}, 16'h0000);
    chk({10'h000, flags}, 16'h0000);
    report_and_stop();
  end
endmodule
